/* File: pcr_pkg.sv */
`default_nettype none
package pcr_pkg;
   // register byte addresses
   localparam logic [7:0] ADDR_CONV_CTRL = 8'h2C;
   localparam logic [7:0] ADDR_SUPPLY_STAT = 8'h30;
   localparam logic [7:0] ADDR_CORE_LEVEL = 8'h34;
   localparam logic [7:0] ADDR_PLL_LEVEL = 8'h40;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h44;
   // converter control fields
   localparam int PG_LSB = 24;
   localparam int ERRCLR_BIT = 16;
   localparam int AUX_ILIM_LSB = 13;
   localparam int AUX_CLK_LSB = 8;
   localparam int CORE_ILIM_LSB = 5;
   localparam int CORE_CLK_LSB = 0;
   localparam logic [1:0] PG_RST = 2'h2;
   localparam logic [1:0] AUX_ILIM_RST = 2'h0;
   localparam logic [1:0] AUX_CLK_RST = 2'h1;
   localparam logic [1:0] CORE_ILIM_RST = 2'h0;
   localparam logic [1:0] CORE_CLK_RST = 2'h1;
   localparam logic ERRCLR_RST = 1'h0;
   // status fields
   localparam int OSC_OK_BIT = 24;
   localparam int PLL_GOOD_BIT = 19;
   localparam int CORE_GOOD_BIT = 16;
   localparam int AUX_ILIM_ACT_BIT = 9;
   localparam int CORE_ILIM_ACT_BIT = 8;
   localparam int AUX_SS_BIT = 1;
   localparam int CORE_SS_BIT = 0;
   localparam logic [31:0] STAT_USED_MASK = 32'h01090303;
   // level fields
   localparam int CORE_LVL_W = 7;
   localparam int PLL_LVL_W = 3;
   localparam logic [6:0] CORE_LVL_MAX = 7'h46;
   localparam logic [31:0] ZERO_WORD = 32'h00000000;
endpackage
`default_nettype wire

/* File: pcr_regs.sv */
`default_nettype none
module pcr_regs
   import pcr_pkg::*;
(
   input wire logic sys_clk, // system clock 200 MHz
   input wire logic rstn, // async reset, active low
   input wire logic [7:0] addr, // byte address
   input wire logic [31:0] wdata, // write data
   input wire logic wr_stb, // write strobe
   input wire logic rd_stb, // read strobe
   output logic [31:0] rdata, // read data, cycle after strobe
   input wire logic [6:0] strap_core_lvl, // strap-derived core level
   input wire logic [2:0] strap_pll_lvl, // strap-derived pll level
   input wire logic osc_stable, // analog: oscillator stable
   input wire logic pll_good, // analog: pll rail good
   input wire logic core_good, // analog: core rail good
   input wire logic aux_ilim_act, // analog: aux buck limiting
   input wire logic core_ilim_act, // analog: core buck limiting
   input wire logic aux_softstart, // analog: aux buck soft start
   input wire logic core_softstart, // analog: core buck soft start
   output logic [1:0] pg_level, // power-good threshold code
   output logic buck_err_clr, // error-flag clear to both bucks
   output logic [1:0] aux_ilim, // aux buck current limit code
   output logic [1:0] aux_clk_sel, // aux buck clock code
   output logic [1:0] core_ilim, // core buck current limit code
   output logic [1:0] core_clk_sel, // core buck clock code
   output logic [6:0] core_lvl, // core rail level code
   output logic [2:0] pll_lvl, // pll rail level code
   output logic irq // level interrupt
);
   typedef struct packed {
      logic [1:0] pg;
      logic errclr;
      logic [1:0] aux_ilim;
      logic [1:0] aux_clk;
      logic [1:0] core_ilim;
      logic [1:0] core_clk;
      logic [6:0] core_lvl;
      logic [2:0] pll_lvl;
      logic strap_done;
      logic [6:0] sync1;
      logic [6:0] sync2;
      logic [6:0] sync3;
      logic [31:0] irq_stat;
      logic [31:0] irq_mask;
      logic irq;
      logic [31:0] rdata;
   } pcr_state_type;

   pcr_state_type st_r, st_nxt;
   logic [31:0] live_stat;
   logic [31:0] ctrl_word;

   // place the live status inputs at their bit positions
   function automatic logic [31:0] pack_stat(input logic [6:0] s);
      logic [31:0] w;
      w = ZERO_WORD;
      w[OSC_OK_BIT] = s[6];
      w[PLL_GOOD_BIT] = s[5];
      w[CORE_GOOD_BIT] = s[4];
      w[AUX_ILIM_ACT_BIT] = s[3];
      w[CORE_ILIM_ACT_BIT] = s[2];
      w[AUX_SS_BIT] = s[1];
      w[CORE_SS_BIT] = s[0];
      return w;
   endfunction

   // status and control views for reads
   always_comb
   begin
      live_stat = pack_stat(st_r.sync2);
      ctrl_word = ZERO_WORD;
      ctrl_word[PG_LSB +: 2] = st_r.pg;
      ctrl_word[ERRCLR_BIT] = st_r.errclr;
      ctrl_word[AUX_ILIM_LSB +: 2] = st_r.aux_ilim;
      ctrl_word[AUX_CLK_LSB +: 2] = st_r.aux_clk;
      ctrl_word[CORE_ILIM_LSB +: 2] = st_r.core_ilim;
      ctrl_word[CORE_CLK_LSB +: 2] = st_r.core_clk;
   end

   // next-state logic
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.sync1 = {osc_stable, pll_good, core_good, aux_ilim_act, core_ilim_act,
                      aux_softstart, core_softstart};
      st_nxt.sync2 = st_r.sync1;
      st_nxt.sync3 = st_r.sync2;
      // straps are caught once, first clock after reset release
      if (!st_r.strap_done)
      begin
         st_nxt.core_lvl = strap_core_lvl;
         st_nxt.pll_lvl = strap_pll_lvl;
         st_nxt.strap_done = 1'b1;
      end
      // register writes; status register ignores writes
      if (wr_stb)
      begin
         case (addr)
            ADDR_CONV_CTRL:
            begin
               st_nxt.pg = wdata[PG_LSB +: 2];
               st_nxt.errclr = wdata[ERRCLR_BIT];
               st_nxt.aux_ilim = wdata[AUX_ILIM_LSB +: 2];
               st_nxt.aux_clk = wdata[AUX_CLK_LSB +: 2];
               st_nxt.core_ilim = wdata[CORE_ILIM_LSB +: 2];
               st_nxt.core_clk = wdata[CORE_CLK_LSB +: 2];
            end
            ADDR_CORE_LEVEL: st_nxt.core_lvl = wdata[CORE_LVL_W-1:0];
            ADDR_PLL_LEVEL: st_nxt.pll_lvl = wdata[PLL_LVL_W-1:0];
            ADDR_IRQ_MASK: st_nxt.irq_mask = wdata & STAT_USED_MASK;
            default: st_nxt.irq_mask = st_r.irq_mask;
         endcase
      end
      // read data, one cycle after the strobe
      st_nxt.rdata = ZERO_WORD;
      if (rd_stb)
      begin
         case (addr)
            ADDR_CONV_CTRL: st_nxt.rdata = ctrl_word;
            ADDR_SUPPLY_STAT: st_nxt.rdata = live_stat;
            ADDR_CORE_LEVEL: st_nxt.rdata = {25'h0000000, st_r.core_lvl};
            ADDR_PLL_LEVEL: st_nxt.rdata = {29'h00000000, st_r.pll_lvl};
            ADDR_IRQ_MASK: st_nxt.rdata = st_r.irq_stat;
            default: st_nxt.rdata = ZERO_WORD;
         endcase
      end
      // sticky event bits: any change of a status input; read clears, set wins
      if (rd_stb && addr == ADDR_IRQ_MASK)
         st_nxt.irq_stat = ZERO_WORD;
      st_nxt.irq_stat = st_nxt.irq_stat | (pack_stat(st_r.sync2 ^ st_r.sync3));
      st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);
   end

   // state register
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         st_r <= '0;
         st_r.pg <= PG_RST;
         st_r.errclr <= ERRCLR_RST;
         st_r.aux_ilim <= AUX_ILIM_RST;
         st_r.aux_clk <= AUX_CLK_RST;
         st_r.core_ilim <= CORE_ILIM_RST;
         st_r.core_clk <= CORE_CLK_RST;
      end
      else
         st_r <= st_nxt;
   end

   // outputs straight from flip-flops
   assign pg_level = st_r.pg;
   assign buck_err_clr = st_r.errclr;
   assign aux_ilim = st_r.aux_ilim;
   assign aux_clk_sel = st_r.aux_clk;
   assign core_ilim = st_r.core_ilim;
   assign core_clk_sel = st_r.core_clk;
   assign core_lvl = st_r.core_lvl;
   assign pll_lvl = st_r.pll_lvl;
   assign irq = st_r.irq;
   assign rdata = st_r.rdata;

   // control write lands next cycle
   chk_ctrl_write: assert property (@(posedge sys_clk) disable iff (!rstn)
      wr_stb && addr == ADDR_CONV_CTRL |=> pg_level == $past(wdata[25:24]))
      else $error("power-good code not written");
   chk_errclr_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
      !(wr_stb && addr == ADDR_CONV_CTRL) |=> buck_err_clr == $past(buck_err_clr))
      else $error("error clear changed without write");
   chk_aux_fields: assert property (@(posedge sys_clk) disable iff (!rstn)
      wr_stb && addr == ADDR_CONV_CTRL |=> aux_ilim == $past(wdata[14:13])
      && aux_clk_sel == $past(wdata[9:8]))
      else $error("aux fields wrong");
   chk_core_fields: assert property (@(posedge sys_clk) disable iff (!rstn)
      wr_stb && addr == ADDR_CONV_CTRL |=> core_ilim == $past(wdata[6:5])
      && core_clk_sel == $past(wdata[1:0]))
      else $error("core fields wrong");
   chk_osc_status: assert property (@(posedge sys_clk) disable iff (!rstn)
      rd_stb && addr == ADDR_SUPPLY_STAT |=> rdata[24] == $past(osc_stable, 3))
      else $error("oscillator status wrong");
   chk_rail_status: assert property (@(posedge sys_clk) disable iff (!rstn)
      rd_stb && addr == ADDR_SUPPLY_STAT |=> rdata[19] == $past(pll_good, 3)
      && rdata[16] == $past(core_good, 3))
      else $error("rail status wrong");
   chk_limit_ss: assert property (@(posedge sys_clk) disable iff (!rstn)
      rd_stb && addr == ADDR_SUPPLY_STAT |=> rdata[9:8] == {$past(aux_ilim_act, 3),
      $past(core_ilim_act, 3)} && rdata[1:0] == {$past(aux_softstart, 3),
      $past(core_softstart, 3)})
      else $error("converter status wrong");
   chk_core_level: assert property (@(posedge sys_clk) disable iff (!rstn)
      wr_stb && addr == ADDR_CORE_LEVEL |=> core_lvl == $past(wdata[6:0]))
      else $error("core level not written");
   chk_pll_level: assert property (@(posedge sys_clk) disable iff (!rstn)
      wr_stb && addr == ADDR_PLL_LEVEL |=> pll_lvl == $past(wdata[2:0]))
      else $error("pll level not written");
   chk_strap_load: assert property (@(posedge sys_clk) disable iff (!rstn)
      !st_r.strap_done |=> core_lvl == $past(strap_core_lvl)
      && pll_lvl == $past(strap_pll_lvl))
      else $error("strap level not loaded");
   chk_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
      rd_stb && addr == ADDR_CORE_LEVEL |=> rdata[31:7] == 25'h0000000)
      else $error("reserved bits not zero");

   // read data return to zero outside the answer cycle
   chk_rdata_idle: assert property (@(posedge sys_clk) disable iff (!rstn)
      !rd_stb |=> rdata == ZERO_WORD)
      else $error("read data not idle");

   // reserved status positions stay clear
   chk_stat_reserved: assert property (@(posedge sys_clk) disable iff (!rstn)
      rd_stb && addr == ADDR_SUPPLY_STAT |=> (rdata & ~STAT_USED_MASK) == ZERO_WORD)
      else $error("status reserved bits set");

   // reserved control positions stay clear
   chk_ctrl_reserved: assert property (@(posedge sys_clk) disable iff (!rstn)
      rd_stb && addr == ADDR_CONV_CTRL |=> (rdata & 32'hFCFE9C9C) == ZERO_WORD)
      else $error("control reserved bits set");

   // reserved pll level positions stay clear
   chk_pll_reserved: assert property (@(posedge sys_clk) disable iff (!rstn)
      rd_stb && addr == ADDR_PLL_LEVEL |=> rdata[31:3] == 29'h00000000)
      else $error("pll reserved bits set");

   // control fields hold between writes
   chk_ctrl_stable: assert property (@(posedge sys_clk) disable iff (!rstn)
      !(wr_stb && addr == ADDR_CONV_CTRL) |=> $stable(pg_level) && $stable(aux_ilim)
      && $stable(aux_clk_sel) && $stable(core_ilim) && $stable(core_clk_sel))
      else $error("control field moved without write");

   // core level holds between writes once straps are in
   chk_core_stable: assert property (@(posedge sys_clk) disable iff (!rstn)
      st_r.strap_done && !(wr_stb && addr == ADDR_CORE_LEVEL) |=> $stable(core_lvl))
      else $error("core level moved without write");

   // pll level holds between writes once straps are in
   chk_pll_stable: assert property (@(posedge sys_clk) disable iff (!rstn)
      st_r.strap_done && !(wr_stb && addr == ADDR_PLL_LEVEL) |=> $stable(pll_lvl))
      else $error("pll level moved without write");
endmodule
`default_nettype wire

/* File: pcr_analog_model.sv */
`default_nettype none
// stands in for the bucks, the linear regulator and the oscillator health lines
module pcr_analog_model (
   input wire logic sys_clk, // system clock
   input wire logic [6:0] stim, // health pattern asked by the bench
   input wire logic buck_err_clr, // error-flag clear from the block
   output logic [6:0] health // osc, pll, core, aux lim, core lim, aux ss, core ss
);
   timeunit 1ns;
   timeprecision 1ps;
   // health follows the request, limit flags held low while the clear stands
   always_ff @(posedge sys_clk)
   begin
      health <= buck_err_clr ? (stim & 7'h73) : stim;
   end
endmodule
`default_nettype wire

/* File: pcr_regs_bench.sv */
`default_nettype none
module pcr_regs_bench
   import pcr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h00000000;
   logic wr_stb = 1'b0;
   logic rd_stb = 1'b0;
   logic [6:0] strap_core_lvl = 7'h00;
   logic [2:0] strap_pll_lvl = 3'h0;
   logic [6:0] stim = 7'h00;
   logic [6:0] health;
   logic [31:0] rdata;
   logic [1:0] pg_level, aux_ilim, aux_clk_sel, core_ilim, core_clk_sel;
   logic buck_err_clr, irq;
   logic [6:0] core_lvl;
   logic [2:0] pll_lvl;
   logic [31:0] ctl_view, seed, d, v;
   int mismatches = 0;
   int n_tests = 0;
   // control outputs folded back into the register layout
   assign ctl_view = {6'h00, pg_level, 7'h00, buck_err_clr, 1'b0, aux_ilim, 3'h0, aux_clk_sel,
      1'b0, core_ilim, 3'h0, core_clk_sel};
   pcr_analog_model far (.sys_clk(sys_clk), .stim(stim), .buck_err_clr(buck_err_clr),
      .health(health));
   pcr_regs uut (.sys_clk(sys_clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
      .rd_stb(rd_stb), .rdata(rdata), .strap_core_lvl(strap_core_lvl),
      .strap_pll_lvl(strap_pll_lvl), .osc_stable(health[6]), .pll_good(health[5]),
      .core_good(health[4]), .aux_ilim_act(health[3]), .core_ilim_act(health[2]),
      .aux_softstart(health[1]), .core_softstart(health[0]), .pg_level(pg_level),
      .buck_err_clr(buck_err_clr), .aux_ilim(aux_ilim), .aux_clk_sel(aux_clk_sel),
      .core_ilim(core_ilim), .core_clk_sel(core_clk_sel), .core_lvl(core_lvl),
      .pll_lvl(pll_lvl), .irq(irq));
   // 200 MHz clock
   initial
   begin
      forever #2.5 sys_clk = ~sys_clk;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   // expected status word for a health pattern
   function automatic logic [31:0] stat_word(input logic [6:0] h);
      return {7'h00, h[6], 4'h0, h[5], 2'h0, h[4], 6'h00, h[3], h[2], 6'h00, h[1], h[0]};
   endfunction
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] dv);
      @(posedge sys_clk);
      addr <= a;
      wdata <= dv;
      wr_stb <= 1'b1;
      @(posedge sys_clk);
      wr_stb <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] dv);
      @(posedge sys_clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge sys_clk);
      rd_stb <= 1'b0;
      // read data stand only in the cycle after the strobe
      #1 dv = rdata;
   endtask
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // watchdog against a hung handshake
   initial
   begin
      #200000;
      mismatches++;
      wrap_up();
   end
   initial
   begin
      seed = xs(32'h00001342);
      strap_core_lvl = 7'(seed % 71);
      strap_pll_lvl = seed[10:8];
      repeat (5) @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (3) @(posedge sys_clk);
      #1 chk("core_lvl", 32'(core_lvl), 32'(strap_core_lvl));
      chk("pll_lvl", 32'(pll_lvl), 32'(strap_pll_lvl));
      rd(ADDR_CONV_CTRL, v);
      chk("ctrl reset", v, 32'h02000101);
      // all ones, all zeros, then random control words
      for (int i = 0; i < 22; i++)
      begin
         seed = xs(seed);
         d = (i == 0) ? 32'hFFFFFFFF : (i == 1) ? 32'h00000000 : seed;
         wr(ADDR_CONV_CTRL, d);
         chk("ctrl outputs", ctl_view, d & 32'h03016363);
         rd(ADDR_CONV_CTRL, v);
         chk("ctrl read", v, d & 32'h03016363);
         wr(ADDR_CORE_LEVEL, seed);
         rd(ADDR_CORE_LEVEL, v);
         chk("core level", v, seed & 32'h0000007F);
         wr(ADDR_PLL_LEVEL, d);
         rd(ADDR_PLL_LEVEL, v);
         chk("pll level", v, d & 32'h00000007);
      end
      // pll raised one code per write, core moved one code per microsecond
      for (int k = 0; k < 8; k++)
      begin
         wr(ADDR_PLL_LEVEL, 32'(k));
         chk("pll step", 32'(pll_lvl), 32'(k));
         wr(ADDR_CORE_LEVEL, 32'(63 + k));
         chk("core step", 32'(core_lvl), 32'(63 + k));
         repeat (200) @(posedge sys_clk);
      end
      wr(ADDR_CONV_CTRL, 32'h00000000);
      for (int i = 0; i < 12; i++)
      begin
         seed = xs(seed);
         stim <= seed[6:0];
         repeat (4) @(posedge sys_clk);
         wr(ADDR_SUPPLY_STAT, 32'hFFFFFFFF);
         rd(ADDR_SUPPLY_STAT, v);
         chk("status", v, stat_word(seed[6:0]));
      end
      stim <= 7'h7F;
      wr(ADDR_CONV_CTRL, 32'h00010000);
      repeat (4) @(posedge sys_clk);
      rd(ADDR_SUPPLY_STAT, v);
      chk("status err clr", v, stat_word(7'h73));
      wr(ADDR_CONV_CTRL, 32'h00000000);
      wr(8'h50, 32'hFFFFFFFF);
      rd(8'h50, v);
      chk("unmapped read", v, ZERO_WORD);
      rd(ADDR_CONV_CTRL, v);
      chk("ctrl after unmapped", v, ZERO_WORD);
      // interrupt: unmasked change raises, read clears, masked change stays quiet
      wr(ADDR_IRQ_MASK, STAT_USED_MASK);
      repeat (6) @(posedge sys_clk);
      rd(ADDR_IRQ_MASK, v);
      repeat (2) @(posedge sys_clk);
      #1 chk("irq idle", 32'(irq), 32'h0);
      for (int m = 0; m < 2; m++)
      begin
         wr(ADDR_IRQ_MASK, m == 0 ? STAT_USED_MASK : ZERO_WORD);
         stim <= stim ^ 7'h01;
         repeat (6) @(posedge sys_clk);
         #1 chk("irq raised", 32'(irq), m == 0 ? 32'h1 : 32'h0);
         rd(ADDR_IRQ_MASK, v);
         chk("event bits", v, 32'h00000001);
         repeat (2) @(posedge sys_clk);
         #1 chk("irq cleared", 32'(irq), 32'h0);
      end
      wrap_up();
   end
endmodule
`default_nettype wire
